// >>> src/bpg_pkg.sv
// Purpose: shared constants for the bus-port gpio control block
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: offsets are register indices on the local port
package bpg_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_PA_DIR = 4'h0;
    localparam logic [3:0] OFS_PA_DATA = 4'h1;
    localparam logic [3:0] OFS_PB_DATA = 4'h2;
    localparam logic [3:0] OFS_PB_DIR = 4'h3;
    localparam logic [3:0] OFS_PE_DATA = 4'h4;
    localparam logic [3:0] OFS_PE_DIR = 4'h5;
    localparam logic [3:0] OFS_PORT_E_FUNCTION_ASSIGN = 4'h6;
    localparam logic [3:0] OFS_PULLUP_CONTROL = 4'h7;
    localparam logic [3:0] OFS_RDRV = 4'h8;
    localparam logic [3:0] OFS_MODE = 4'h9;
    // operating modes (special = bit 2 clear)
    localparam logic [2:0] MD_SPC_SC = 3'h0;
    localparam logic [2:0] MD_SPC_EXN = 3'h1;
    localparam logic [2:0] MD_PERIPH = 3'h2;
    localparam logic [2:0] MD_SPC_EXW = 3'h3;
    localparam logic [2:0] MD_NRM_SC = 3'h4;
    localparam logic [2:0] MD_NRM_EXN = 3'h5;
    localparam logic [2:0] MD_NRM_EXW = 3'h7;
    // function-assign field positions
    localparam int FA_NO_DATA_ENABLE_BIT = 7;
    localparam int FA_TEST = 6;
    localparam int FA_PIPE = 5;
    localparam int FA_NO_E_CLOCK_BIT = 4;
    localparam int FA_LSTR = 3;
    localparam int FA_RDW = 2;
    localparam int FA_WO_HI = 7;
    localparam logic [7:0] FA_ONCE_MASK = 8'hEC;
    localparam logic [7:0] FA_USED_MASK = 8'hFC;
    // function-assign reset values per mode
    localparam logic [7:0] FA_RST_NRM_SC = 8'h90;
    localparam logic [7:0] FA_RST_SPC_SC = 8'h80;
    localparam logic [7:0] FA_RST_NRM_EX = 8'h80;
    localparam logic [7:0] FA_RST_SPC_EX = 8'hAC;
    // pullup and reduced-drive field positions
    localparam int PU_A = 0;
    localparam int PU_B = 1;
    localparam int PU_E = 4;
    localparam logic [7:0] PU_MASK = 8'h13;
    localparam logic [7:0] RD_MASK = 8'h13;
    localparam logic [7:0] PU_RST = 8'h00;
    localparam logic [7:0] RD_RST = 8'h00;
    localparam logic [7:0] PE_PULL_CTL = 8'h8D;
    localparam logic [7:0] PE_PULL_ALWAYS = 8'h02;
    localparam logic [7:0] PE_OUT_OK = 8'hFC;
    // mode register bits
    localparam int MO_EME = 1;
    localparam int MO_INTERNAL_VISIBILITY_BIT = 3;
    localparam int MO_STRETCH_ENABLE_BIT = 0;
endpackage : bpg_pkg

// >>> src/bpg_top.sv
// Purpose: port A, B and E general-purpose control with bus-mode takeover
// Assumes: mode strap sampled after reset release; pins synchronised here
// Notes: register window is 10 byte registers; bus-side function values enter
//        from the bus controller as same-clock inputs
//
// Contract
// - direction bit one drives pin, zero leaves it a high-impedance input
// - ports A and B data and direction leave map in expanded or peripheral
// - port B carries low address/data when bus active, else general I/O
// - port E data/direction absent in peripheral or expanded with emulate bit
// - port E bits 1 and 0 never output, always readable
// - bus-control function selection overrides port E direction bit
// - normal single-chip reset leaves all port E general I/O
// - normal expanded reset enables only E clock on port E
// - special expanded enables pipes, clock, read/write, strobe; special chip clock
// - assign bits write once in normal, all-but-first in special modes
// - no-data-enable one gives general I/O on bit 7, zero data enable outside single-chip
// - pipe enable drives bits 6,5 outside single-chip, beats test output
// - no-E-clock bit stays zero in expanded; once normal, anytime special chip
// - single-chip E clock needs no-E-clock zero and visibility or no stretch
// - low strobe enable makes bit 3 strobe, not single-chip or normal narrow
// - read/write enable makes bit 2 read/write, off in single-chip
// - port E pullup enable covers bits 7,3,2,0; bit 1 always pulled
// - port A, B pullups cover input pins, inactive while port is bus
// - pullups act on inputs only; pullup register absent in peripheral
// - reduced drive per port; write once normal, after first special; absent periph
// - emulate bit in expanded makes port E data/direction external accesses
// - port A carries high address/data when bus active, else general I/O
`timescale 1ns/1ps
module bpg_top
    import bpg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // operating mode strap
    input wire logic [2:0] mode_strap,
    // register port
    input wire logic [bpg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_external,
    // bus controller function values
    input wire logic [7:0] bus_addr_hi,
    input wire logic [7:0] bus_addr_lo,
    input wire logic bus_eclk,
    input wire logic bus_rw,
    input wire logic bus_low_byte_strobe,
    input wire logic bus_dbe,
    input wire logic [1:0] bus_pipe,
    input wire logic bus_test_out,
    // port pins
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pa_pull,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    output logic [7:0] pb_pull,
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe,
    output logic [7:0] pe_pull,
    // drive strength per port (a, b, e)
    output logic [2:0] reduced_drive
);
    import bpg_pkg::*;

    logic [2:0] mode;
    logic mode_loaded;
    logic [7:0] port_a_direction, port_a_data, port_b_data, port_b_direction;
    logic [7:0] port_e_data, port_e_direction, port_e_function_assign;
    logic [7:0] pullup_control, reduced_drive_control, mode_ctl;
    logic fa_written, rd_written, no_e_clock_bit_written;
    logic [7:0] pa_s1, pa_s2, pa_s3, pb_s1, pb_s2, pb_s3, pe_s1, pe_s2, pe_s3;
    logic [7:0] pa_lvl, pb_lvl, pe_lvl;

    // mode decode
    wire is_special = ~mode[2];
    wire is_periph = (mode == MD_PERIPH);
    wire is_single = (mode == MD_NRM_SC) || (mode == MD_SPC_SC);
    wire is_expanded = ~is_single & ~is_periph;
    wire is_narrow = (mode == MD_NRM_EXN) || (mode == MD_SPC_EXN);
    wire bus_ports = ~is_single;
    wire emulate_port_e_bit = mode_ctl[MO_EME];

    // map visibility; a removed port A, B or E register turns into an external access
    wire ab_mapped = is_single;
    wire e_mapped = ~is_periph & ~(is_expanded & emulate_port_e_bit);
    wire ctl_mapped = ~is_periph;

    wire hit_pa_dir = reg_addr == OFS_PA_DIR;
    wire hit_pa_dat = reg_addr == OFS_PA_DATA;
    wire hit_pb_dat = reg_addr == OFS_PB_DATA;
    wire hit_pb_dir = reg_addr == OFS_PB_DIR;
    wire hit_pe_dat = reg_addr == OFS_PE_DATA;
    wire hit_pe_dir = reg_addr == OFS_PE_DIR;
    wire hit_fa = reg_addr == OFS_PORT_E_FUNCTION_ASSIGN;
    wire hit_pu = reg_addr == OFS_PULLUP_CONTROL;
    wire hit_rd = reg_addr == OFS_RDRV;
    wire hit_mo = reg_addr == OFS_MODE;
    wire ab_hit = hit_pa_dir | hit_pa_dat | hit_pb_dat | hit_pb_dir;
    wire e_hit = hit_pe_dat | hit_pe_dir;
    wire ctl_hit = hit_fa | hit_pu | hit_rd;
    wire ext_access = (ab_hit & ~ab_mapped) | (e_hit & ~e_mapped);
    wire wr_ab = reg_wr & ab_mapped;
    wire wr_e = reg_wr & e_mapped;
    wire wr_ctl = reg_wr & ctl_mapped;

    // write-once in normal, skip-first in special
    wire fa_once_ok = is_special ? fa_written : ~fa_written;
    wire rd_once_ok = is_special ? rd_written : ~rd_written;
    wire no_e_clock_bit_ok = is_single & (is_special | ~no_e_clock_bit_written);
    wire [7:0] fa_lock_mask = (fa_once_ok ? FA_ONCE_MASK : 8'h00)
                            | (no_e_clock_bit_ok ? 8'h10 : 8'h00);
    wire [7:0] next_fa = (port_e_function_assign & ~fa_lock_mask)
                       | (reg_wdata & fa_lock_mask);

    // function-assign reset value by mode
    wire [7:0] fa_reset_val = (mode == MD_NRM_SC) ? FA_RST_NRM_SC :
                              (mode == MD_SPC_SC) ? FA_RST_SPC_SC :
                              is_special ? FA_RST_SPC_EX : FA_RST_NRM_EX;

    // strap capture after release; the function register is loaded with it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= MD_NRM_SC;
            mode_loaded <= 1'b0;
        end else if (!mode_loaded) begin
            mode <= mode_strap;
            mode_loaded <= 1'b1;
        end
    end

    // ports A and B registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_direction <= 8'h00;
            port_a_data <= 8'h00;
            port_b_direction <= 8'h00;
            port_b_data <= 8'h00;
        end else if (wr_ab) begin
            if (hit_pa_dir) port_a_direction <= reg_wdata;
            if (hit_pa_dat) port_a_data <= reg_wdata;
            if (hit_pb_dir) port_b_direction <= reg_wdata;
            if (hit_pb_dat) port_b_data <= reg_wdata;
        end
    end

    // port E data and direction; bits 1:0 cannot become outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_e_data <= 8'h00;
            port_e_direction <= 8'h00;
        end else if (wr_e) begin
            if (hit_pe_dat) port_e_data <= reg_wdata;
            if (hit_pe_dir) port_e_direction <= reg_wdata & PE_OUT_OK;
        end
    end

    // function-assign register and its write history
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_e_function_assign <= FA_RST_NRM_SC;
            fa_written <= 1'b0;
            no_e_clock_bit_written <= 1'b0;
        end else if (!mode_loaded) begin
            port_e_function_assign <= (mode_strap == MD_NRM_SC) ? FA_RST_NRM_SC :
                                      (mode_strap == MD_SPC_SC) ? FA_RST_SPC_SC :
                                      ~mode_strap[2] ? FA_RST_SPC_EX : FA_RST_NRM_EX;
        end else if (wr_ctl && hit_fa) begin
            port_e_function_assign <= next_fa;
            fa_written <= 1'b1;
            no_e_clock_bit_written <= no_e_clock_bit_written | is_single;
        end else if (is_expanded) begin
            port_e_function_assign[FA_NO_E_CLOCK_BIT] <= 1'b0;
        end
    end

    // pullup, reduced drive and mode control
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pullup_control <= PU_RST;
            reduced_drive_control <= RD_RST;
            rd_written <= 1'b0;
            mode_ctl <= 8'h00;
        end else if (wr_ctl) begin
            if (hit_pu) pullup_control <= reg_wdata & PU_MASK;
            if (hit_rd && rd_once_ok) reduced_drive_control <= reg_wdata & RD_MASK;
            if (hit_rd) rd_written <= 1'b1;
            if (hit_mo) mode_ctl <= reg_wdata;
        end
    end

    // pin synchronisers, a change counts when stages two and three agree
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {pa_s1, pa_s2, pa_s3} <= '0;
            {pb_s1, pb_s2, pb_s3} <= '0;
            {pe_s1, pe_s2, pe_s3} <= '0;
            {pa_lvl, pb_lvl, pe_lvl} <= '0;
        end else begin
            {pa_s1, pa_s2, pa_s3} <= {pa_in, pa_s1, pa_s2};
            {pb_s1, pb_s2, pb_s3} <= {pb_in, pb_s1, pb_s2};
            {pe_s1, pe_s2, pe_s3} <= {pe_in, pe_s1, pe_s2};
            pa_lvl <= (pa_s2 & pa_s3) | (pa_lvl & (pa_s2 | pa_s3));
            pb_lvl <= (pb_s2 & pb_s3) | (pb_lvl & (pb_s2 | pb_s3));
            pe_lvl <= (pe_s2 & pe_s3) | (pe_lvl & (pe_s2 | pe_s3));
        end
    end

    // port E function selection per pin
    wire [7:0] fa = port_e_function_assign;
    wire sel_dbe = ~is_single & ~fa[FA_NO_DATA_ENABLE_BIT];
    wire sel_pipe = ~is_single & fa[FA_PIPE];
    wire sel_test = fa[FA_TEST] & is_special & ~is_single & ~sel_pipe;
    wire sel_eclk = ~fa[FA_NO_E_CLOCK_BIT] & (is_expanded
                    | (mode_ctl[MO_INTERNAL_VISIBILITY_BIT] | ~mode_ctl[MO_STRETCH_ENABLE_BIT]));
    wire sel_lstr = fa[FA_LSTR] & ~is_single & ~(is_narrow & ~is_special);
    wire sel_rdw = fa[FA_RDW] & ~is_single;
    wire [7:0] pe_alt = {sel_dbe, sel_pipe | sel_test, sel_pipe, sel_eclk,
                         sel_lstr, sel_rdw, 2'b00};
    wire [7:0] pe_alt_val = {bus_dbe, sel_pipe ? bus_pipe[1] : bus_test_out,
                             bus_pipe[0], bus_eclk, bus_low_byte_strobe, bus_rw, 2'b00};
    // alternate function overrides the direction bit
    wire [7:0] pe_dir_eff = (pe_alt | (port_e_direction & ~pe_alt)) & PE_OUT_OK;
    wire [7:0] pe_out_eff = (pe_alt & pe_alt_val) | (~pe_alt & port_e_data);
    wire [7:0] pa_dir_eff = bus_ports ? 8'hFF : port_a_direction;
    wire [7:0] pb_dir_eff = bus_ports ? 8'hFF : port_b_direction;
    wire [7:0] pa_out_eff = bus_ports ? bus_addr_hi : port_a_data;
    wire [7:0] pb_out_eff = bus_ports ? bus_addr_lo : port_b_data;

    // pullups only on inputs, never on ports serving the bus
    wire [7:0] pa_pull_eff = {8{pullup_control[PU_A] & ~bus_ports}} & ~pa_dir_eff;
    wire [7:0] pb_pull_eff = {8{pullup_control[PU_B] & ~bus_ports}} & ~pb_dir_eff;
    wire [7:0] pe_pull_eff = (({8{pullup_control[PU_E]}} & PE_PULL_CTL)
                              | PE_PULL_ALWAYS) & ~pe_dir_eff;

    // read mux: pins for inputs, latch for outputs
    wire [7:0] pa_rd = (pa_lvl & ~port_a_direction) | (port_a_data & port_a_direction);
    wire [7:0] pb_rd = (pb_lvl & ~port_b_direction) | (port_b_data & port_b_direction);
    wire [7:0] pe_rd = (pe_lvl & ~pe_dir_eff) | (port_e_data & pe_dir_eff);
    wire [7:0] rd_mux = (hit_pa_dir && ab_mapped) ? port_a_direction :
                        (hit_pa_dat && ab_mapped) ? pa_rd :
                        (hit_pb_dat && ab_mapped) ? pb_rd :
                        (hit_pb_dir && ab_mapped) ? port_b_direction :
                        (hit_pe_dat && e_mapped) ? pe_rd :
                        (hit_pe_dir && e_mapped) ? port_e_direction :
                        (hit_fa && ctl_mapped) ? (fa & FA_USED_MASK) :
                        (hit_pu && ctl_mapped) ? pullup_control :
                        (hit_rd && ctl_mapped) ? reduced_drive_control :
                        hit_mo ? mode_ctl : 8'h00;
    wire unused_ok = ctl_hit;

    // registered outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_external <= 1'b0;
            {pa_out, pa_oe, pa_pull} <= '0;
            {pb_out, pb_oe, pb_pull} <= '0;
            {pe_out, pe_oe, pe_pull} <= '0;
            reduced_drive <= 3'b000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            reg_external <= (reg_rd | reg_wr) & ext_access;
            pa_out <= pa_out_eff;
            pa_oe <= pa_dir_eff;
            pa_pull <= pa_pull_eff;
            pb_out <= pb_out_eff;
            pb_oe <= pb_dir_eff;
            pb_pull <= pb_pull_eff;
            pe_out <= pe_out_eff;
            pe_oe <= pe_dir_eff;
            pe_pull <= pe_pull_eff;
            // reduced drive regardless of pin function
            reduced_drive <= {reduced_drive_control[PU_E], reduced_drive_control[PU_B],
                              reduced_drive_control[PU_A]};
        end
    end
endmodule : bpg_top

// >>> dv/bpg_asserts.sv
// Purpose: port-level checks for bpg_top
// Assumes: mode strap only changes while reset is held
// Notes: bound to bpg_top below
`timescale 1ns/1ps
module bpg_asserts
    import bpg_pkg::*;
(
    // clock, reset and mode
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] mode_strap,
    // register port
    input wire logic [bpg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_external,
    // pin controls
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pa_pull,
    input wire logic [7:0] pb_oe,
    input wire logic [7:0] pb_pull,
    input wire logic [7:0] pe_oe,
    input wire logic [7:0] pe_pull,
    input wire logic [2:0] reduced_drive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // access decode; the strap is steady after reset so it stands for the mode
    wire logic acc;
    wire logic one_chip;
    assign acc = reg_rd | reg_wr;
    assign one_chip = (mode_strap == MD_NRM_SC) || (mode_strap == MD_SPC_SC);
    sequence s_ab_acc;
        acc && (reg_addr <= OFS_PB_DIR);
    endsequence
    sequence s_pe_acc;
        acc && ((reg_addr == OFS_PE_DATA) || (reg_addr == OFS_PE_DIR));
    endsequence
    chk_ab_goes_external: assert property (!one_chip ##0 s_ab_acc |=> reg_external)
        else $error("port a/b access stayed internal");
    chk_chip_stays_local: assert property (one_chip ##0 (s_ab_acc or s_pe_acc) |=> !reg_external)
        else $error("single-chip port access went external");
    chk_pe_periph_ext: assert property ((mode_strap == MD_PERIPH) ##0 s_pe_acc |=> reg_external)
        else $error("port e register mapped in peripheral mode");
    chk_pe_low_input: assert property (pe_oe[1:0] == 2'h0)
        else $error("interrupt pin driven");
    chk_pull_inputs_only: assert property (((pa_pull & pa_oe) | (pb_pull & pb_oe)) == 8'h00)
        else $error("pullup on an output pin");
    chk_pe_fixed_pull: assert property (!$past(sys_rst) |-> pe_pull[1] && (pe_pull[6:4] == 3'h0))
        else $error("fixed port e pullups wrong");
    chk_rdata_after_read: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without a read");
    chk_ext_after_access: assert property (reg_external |-> $past(acc))
        else $error("external flag without access");
    // two flops between the strobe and the pin control, so look back two cycles
    chk_drive_by_write: assert property ($changed(reduced_drive) |-> $past(reg_wr, 2) && ($past(reg_addr, 2) == OFS_RDRV))
        else $error("drive strength moved without write");
endmodule : bpg_asserts
bind bpg_top bpg_asserts u_chk (.sys_clk, .sys_rst, .mode_strap, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .reg_external, .pa_oe, .pa_pull, .pb_oe, .pb_pull, .pe_oe, .pe_pull,
    .reduced_drive);

// >>> dv/bpg_pins.sv
// Purpose: external pin model for one 8-bit port
// Assumes: one instance per port
// Notes: undriven, unpulled lines wander so stale values never look valid
`timescale 1ns/1ps
module bpg_pins (
    // clock
    input wire logic sys_clk,
    // device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull,
    // level seen at the pin
    output logic [7:0] pin_lvl
);
    logic [7:0] float_pat = 8'h5A;
    // floating lines toggle every cycle
    always @(posedge sys_clk) begin
        float_pat <= ~float_pat;
    end
    // driven bits show the latch, released bits the pullup or noise
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & (pin_pull | float_pat));
endmodule : bpg_pins

// >>> dv/tb.sv
// Purpose: self-checking bench for bpg_top
// Assumes: mode is chosen by strap during reset
// Notes: every mode change goes through a fresh reset
`timescale 1ns/1ps
module tb;
    import bpg_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] mode_strap = MD_NRM_SC;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, pa_in, pa_out, pa_oe, pa_pull, pb_in, pb_out, pb_oe, pb_pull;
    logic [7:0] pe_in, pe_out, pe_oe, pe_pull, d;
    logic reg_external, x;
    logic [2:0] reduced_drive;
    logic [15:0] cyc = 16'h0000;
    int err_total = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    // bus-side values move every cycle; watchdog cuts a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 16'h0001;
        if (cyc == 16'h0FA0) begin
            err_total++;
            end_of_test();
        end
    end
    bpg_top uut (.sys_clk, .sys_rst, .mode_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_external, .bus_addr_hi(cyc[15:8]), .bus_addr_lo(cyc[7:0]),
        .bus_eclk(cyc[0]), .bus_rw(cyc[1]), .bus_low_byte_strobe(cyc[2]), .bus_dbe(cyc[3]),
        .bus_pipe(cyc[5:4]), .bus_test_out(cyc[6]), .pa_in, .pa_out, .pa_oe, .pa_pull,
        .pb_in, .pb_out, .pb_oe, .pb_pull, .pe_in, .pe_out, .pe_oe, .pe_pull, .reduced_drive);
    bpg_pins u_pa (.sys_clk, .pin_out(pa_out), .pin_oe(pa_oe), .pin_pull(pa_pull), .pin_lvl(pa_in));
    bpg_pins u_pb (.sys_clk, .pin_out(pb_out), .pin_oe(pb_oe), .pin_pull(pb_pull), .pin_lvl(pb_in));
    bpg_pins u_pe (.sys_clk, .pin_out(pe_out), .pin_oe(pe_oe), .pin_pull(pe_pull), .pin_lvl(pe_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rst(input logic [2:0] m);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        mode_strap <= m;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
    endtask : rst
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data and external flag stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        x = reg_external;
    endtask : rd
    task automatic t_nrm_chip;
        rst(MD_NRM_SC);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, FA_RST_NRM_SC);
        wr(OFS_PB_DIR, 8'h0F);
        wr(OFS_PB_DATA, 8'h05);
        wr(OFS_PULLUP_CONTROL, PU_MASK);
        wr(OFS_PE_DIR, 8'hFF);
        wr(OFS_PE_DATA, 8'hA4);
        repeat (6) @(posedge sys_clk);
        chk(pb_oe, 8'h0F);
        chk(pb_out, 8'h05);
        chk(pe_out, 8'hA4);
        chk(pe_oe, 8'hFC);
        chk(pe_pull, 8'h03);
        chk(pa_pull, 8'hFF);
        chk(pb_pull, 8'hF0);
        rd(OFS_PB_DATA); chk(d, 8'hF5);
        chk({7'h00, x}, 8'h00);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h00);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'hFC);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, 8'h00);
        wr(OFS_RDRV, RD_MASK);
        wr(OFS_RDRV, 8'h00);
        rd(OFS_RDRV); chk(d, RD_MASK);
        chk({5'h00, reduced_drive}, 8'h07);
        rd(4'hF);
    endtask : t_nrm_chip
    task automatic t_nrm_exp;
        rst(MD_NRM_EXN);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, FA_RST_NRM_EX);
        rd(OFS_PA_DIR); chk({7'h00, x}, 8'h01);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h9C);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, 8'h8C);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h80);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, 8'h8C);
        wr(OFS_PULLUP_CONTROL, PU_MASK);
        repeat (3) @(posedge sys_clk);
        chk(pa_pull | pb_pull, 8'h00);
        chk({6'h00, pe_oe[4], pe_oe[2]}, 8'h03);
        chk({7'h00, pe_oe[3]}, 8'h00);
        chk(pa_oe, 8'hFF);
        chk(pb_oe, 8'hFF);
        rst(MD_NRM_EXW);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h08);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, pe_oe[3]}, 8'h01);
        chk({7'h00, pe_oe[7]}, 8'h01);
    endtask : t_nrm_exp
    task automatic t_periph;
        rst(MD_PERIPH);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, 8'h00);
        rd(OFS_PE_DATA); chk({7'h00, x}, 8'h01);
        rd(OFS_PULLUP_CONTROL); chk(d, 8'h00);
    endtask : t_periph
    task automatic t_special;
        rst(MD_SPC_EXW);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, FA_RST_SPC_EX);
        chk({6'h00, pe_oe[6:5]}, 8'h03);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h00);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, FA_RST_SPC_EX);
        wr(OFS_PORT_E_FUNCTION_ASSIGN, 8'h80);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, 8'h80);
        wr(OFS_MODE, 8'h02);
        rd(OFS_PE_DIR); chk({7'h00, x}, 8'h01);
        rst(MD_SPC_SC);
        rd(OFS_PORT_E_FUNCTION_ASSIGN); chk(d, FA_RST_SPC_SC);
        wr(OFS_RDRV, RD_MASK);
        rd(OFS_RDRV); chk(d, RD_RST);
        wr(OFS_RDRV, RD_MASK);
        rd(OFS_RDRV); chk(d, RD_MASK);
    endtask : t_special
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        t_nrm_chip();
        t_nrm_exp();
        t_periph();
        t_special();
        end_of_test();
    end
endmodule : tb
